// File: rtl/sic_top.sv
// service pin override and condition indicator sequencing
//
// Behaviour
// - service input low forces primary serial port to 38400 baud, 8N1
// - service input never touches stored settings, only format and command set enable
// - service input high restores configured serial port settings
// - command set counts as enabled while service input is low
// - indicator statically high while searching for a new frame
// - indicator low for the whole of each received frame
// - indicator statically low in light sleep state
// - indicator toggles at each transmission interval while transmitting
// - indicator toggles every 1 s while a configuration tool is connected
// - indicator toggles every 500 ms when command mode off but escape-enabled
// - indicator toggles every 250 ms on fault; fault code stays readable
// - fault blocks radio transmit and receive, reboot 5 s after entry
//
// intervals are counted in millisecond enables, so a first blink may run
// one tick short; steady indications never look at the blink timer
`timescale 1ns/100ps
`default_nettype none
`include "sic_params.svh"
module sic_top #(
    parameter int TICK_CYCLES = `SIC_TICK_CYCLES,
    parameter int TOOL_MS = `SIC_TOOL_MS,
    parameter int CMD_MS = `SIC_CMD_MS,
    parameter int FAULT_MS = `SIC_FAULT_MS,
    parameter int REBOOT_MS = `SIC_REBOOT_MS
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_service_n,
    input wire sic_pkg::sic_uart_cfg_t i_cfg_uart,
    input wire logic i_cfg_cmd_enable,
    input wire sic_pkg::sic_cond_t i_cond,
    input wire logic [7:0] i_fault_code,
    output sic_pkg::sic_uart_cfg_t o_primary_host_serial_port,
    output logic o_vendor_config_command_set,
    output logic o_service_active,
    output logic o_indicator,
    output logic o_radio_block,
    output logic o_reboot,
    output logic [7:0] o_fault_code
);
    import sic_pkg::*;

    // fixed service format: 38400 baud, eight data bits, no parity, one stop bit
    localparam sic_uart_cfg_t SERVICE_CFG = '{
        baud: 24'(`SIC_SERVICE_BAUD),
        data_bits: `SIC_SERVICE_DATA_BITS,
        parity: `SIC_SERVICE_PARITY_NONE,
        stop_bits: `SIC_SERVICE_STOP_BITS
    };
    // one width for both timers; limitation: no blink period may exceed the reboot count
    localparam int TW = $clog2(REBOOT_MS + 1);

    // service pin synchroniser, two flops
    logic service_meta_reg;
    logic service_sync_reg;

    // millisecond enable from the divider
    logic ms_tick;

    // indication shown now and the one the conditions ask for
    sic_ind_t ind_reg;
    sic_ind_t ind_next;

    // blink timer and its reload for the current indication
    logic [TW-1:0] blink_reg;
    logic [TW-1:0] half_period;

    // reboot timer and the once-per-episode latch
    logic [TW-1:0] reboot_reg;
    logic fault_seen_reg;

    sic_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .o_ms_tick(ms_tick)
    );

    // pin comes from the host, so two flops; idle high like the pull-up
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            service_meta_reg <= 1'b1;
            service_sync_reg <= 1'b1;
        end else begin
            service_meta_reg <= i_service_n;
            service_sync_reg <= service_meta_reg;
        end
    end

    // format override and forced command set; stored config is passed through untouched
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_primary_host_serial_port <= SERVICE_CFG;
            o_vendor_config_command_set <= 1'b0;
            o_service_active <= 1'b0;
        end else begin
            o_service_active <= !service_sync_reg;
            if (!service_sync_reg) begin
                o_primary_host_serial_port <= SERVICE_CFG;
            end else begin
                o_primary_host_serial_port <= i_cfg_uart;
            end
            // stored enable passes through; service forces the set on
            o_vendor_config_command_set <= i_cfg_cmd_enable || !service_sync_reg;
        end
    end

    // indication priority, fault first
    always_comb begin
        if (i_cond.fault) begin
            ind_next = SIC_IND_FAULT;
        end else if (i_cond.tool_conn) begin
            ind_next = SIC_IND_TOOL;
        end else if (i_cond.cmd_escape) begin
            ind_next = SIC_IND_CMD;
        end else if (i_cond.transmitting) begin
            ind_next = SIC_IND_TX;
        end else if (i_cond.light_sleep) begin
            ind_next = SIC_IND_SLEEP;
        end else if (i_cond.receiving) begin
            ind_next = SIC_IND_RECV;
        end else begin
            ind_next = SIC_IND_SEARCH;
        end
    end

    // reload for the blink timer; steady indications never use it
    always_comb begin
        unique case (ind_reg)
            SIC_IND_TOOL: half_period = TW'(TOOL_MS);
            SIC_IND_CMD: half_period = TW'(CMD_MS);
            SIC_IND_FAULT: half_period = TW'(FAULT_MS);
            default: half_period = TW'(FAULT_MS);
        endcase
    end

    // registered indication, compared with the next to restart the blink timer
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ind_reg <= SIC_IND_SEARCH;
        end else begin
            ind_reg <= ind_next;
        end
    end

    // indicator level; blink timer restarts on every change of indication
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_indicator <= 1'b1;
            blink_reg <= '0;
        end else if (ind_next != ind_reg) begin
            blink_reg <= '0;
            unique case (ind_next)
                SIC_IND_SEARCH: o_indicator <= 1'b1;
                SIC_IND_RECV: o_indicator <= 1'b0;
                SIC_IND_SLEEP: o_indicator <= 1'b0;
                default: o_indicator <= !o_indicator;
            endcase
        end else begin
            unique case (ind_reg)
                SIC_IND_SEARCH: o_indicator <= 1'b1;
                SIC_IND_RECV: o_indicator <= 1'b0;
                SIC_IND_SLEEP: o_indicator <= 1'b0;
                SIC_IND_TX: begin
                    // one toggle per transmitted packet
                    if (i_cond.tx_event) begin
                        o_indicator <= !o_indicator;
                    end
                end
                default: begin
                    if (ms_tick) begin
                        // interval measured level change to level change
                        if (blink_reg == half_period - 1'b1) begin
                            blink_reg <= '0;
                            o_indicator <= !o_indicator;
                        end else begin
                            blink_reg <= blink_reg + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // fault: radio blocked at once, reboot pulse 5 s after entry
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reboot_reg <= '0;
            fault_seen_reg <= 1'b0;
            o_reboot <= 1'b0;
            o_radio_block <= 1'b0;
        end else begin
            o_radio_block <= i_cond.fault;
            o_reboot <= 1'b0;
            // a dropped fault rearms the timer for the next episode
            if (!i_cond.fault) begin
                reboot_reg <= '0;
                fault_seen_reg <= 1'b0;
            end else if (!fault_seen_reg && ms_tick) begin
                if (reboot_reg == TW'(REBOOT_MS - 1)) begin
                    fault_seen_reg <= 1'b1; // single pulse per fault entry
                    o_reboot <= 1'b1;
                end else begin
                    reboot_reg <= reboot_reg + 1'b1;
                end
            end
        end
    end

    // fault code held so tools can read it across the fault
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fault_code <= 8'h00;
        end else if (i_cond.fault) begin
            o_fault_code <= i_fault_code;
        end
    end
endmodule
`default_nettype wire

// File: rtl/sic_params.svh
// timing and format constants for the service and indicator control block
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH
`define SIC_CLK_HZ 250000000
`define SIC_SERVICE_BAUD 38400
`define SIC_SERVICE_DATA_BITS 4'h8
`define SIC_SERVICE_PARITY_NONE 2'h0
`define SIC_SERVICE_STOP_BITS 2'h1
`define SIC_TICK_US 1000
`define SIC_TICK_CYCLES ((`SIC_CLK_HZ / 1000000) * `SIC_TICK_US)
`define SIC_TOOL_MS 1000
`define SIC_CMD_MS 500
`define SIC_FAULT_MS 250
`define SIC_REBOOT_MS 5000
`endif

// File: rtl/sic_pkg.sv
// types shared by the service and indicator control block
package sic_pkg;
    // serial port format: baud rate, data bits, parity code, stop bits
    typedef struct packed {
        logic [23:0] baud;
        logic [3:0] data_bits;
        logic [1:0] parity;
        logic [1:0] stop_bits;
    } sic_uart_cfg_t;

    // operating condition reported by the module core
    typedef struct packed {
        logic fault;
        logic tool_conn;
        logic cmd_escape;
        logic transmitting;
        logic tx_event;
        logic light_sleep;
        logic receiving;
    } sic_cond_t;

    typedef enum logic [6:0] {
        SIC_IND_SEARCH = 7'h01,
        SIC_IND_RECV   = 7'h02,
        SIC_IND_SLEEP  = 7'h04,
        SIC_IND_TX     = 7'h08,
        SIC_IND_TOOL   = 7'h10,
        SIC_IND_CMD    = 7'h20,
        SIC_IND_FAULT  = 7'h40
    } sic_ind_t;
endpackage

// File: rtl/sic_tick.sv
// millisecond tick divider for the indicator and reboot timers
`timescale 1ns/100ps
`default_nettype none
`include "sic_params.svh"
module sic_tick #(
    parameter int TICK_CYCLES = `SIC_TICK_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    output logic o_ms_tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    logic [CW-1:0] count_reg;

    // one-cycle enable every millisecond; the only slow rate in the block
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_reg <= '0;
            o_ms_tick <= 1'b0;
        end else if (count_reg == CW'(TICK_CYCLES - 1)) begin
            count_reg <= '0;
            o_ms_tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            o_ms_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: dv/sic_top_checker.sv
// assertions on the service and indicator ports
`timescale 1ns/100ps
`default_nettype none
module sic_top_checker #(
    parameter int TICK_CYCLES = 10,
    parameter int FAULT_MS = 2,
    parameter int REBOOT_MS = 20
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_service_n,
    input wire sic_pkg::sic_uart_cfg_t i_cfg_uart,
    input wire sic_pkg::sic_cond_t i_cond,
    input wire sic_pkg::sic_uart_cfg_t o_primary_host_serial_port,
    input wire logic o_vendor_config_command_set,
    input wire logic o_indicator,
    input wire logic o_radio_block,
    input wire logic o_reboot
);
    import sic_pkg::*;
    // one or two cycles of slack: the tick counter runs free
    localparam int FLT_MAX = FAULT_MS * TICK_CYCLES + 1;
    localparam int REB_HI = REBOOT_MS * TICK_CYCLES + 2;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    svc_fmt_a: assert property (!i_service_n[*4] |->
        o_primary_host_serial_port == {24'h009600, 4'h8, 2'h0, 2'h1}) else $error("service fmt");
    svc_restore_a: assert property ((i_service_n && $stable(i_cfg_uart))[*4] |->
        o_primary_host_serial_port == i_cfg_uart) else $error("cfg not restored");
    cmd_forced_a: assert property (!i_service_n[*4] |-> o_vendor_config_command_set)
        else $error("cmd set off");
    search_high_a: assert property ((i_cond == 7'h00)[*2] |-> o_indicator)
        else $error("search low");
    recv_low_a: assert property ((i_cond == 7'h01)[*2] |-> !o_indicator)
        else $error("recv high");
    sleep_low_a: assert property ((i_cond == 7'h02)[*2] |-> !o_indicator)
        else $error("sleep high");
    tx_toggle_a: assert property (i_cond == 7'h0c && $past(i_cond.transmitting) |=>
        o_indicator != $past(o_indicator)) else $error("tx no toggle");
    fault_block_a: assert property (i_cond.fault |=> o_radio_block)
        else $error("radio not blocked");
    fault_blink_a: assert property (i_cond.fault && $changed(o_indicator) |->
        ##[1:FLT_MAX] ($changed(o_indicator) || !i_cond.fault)) else $error("fault blink");
    reboot_due_a: assert property ($rose(i_cond.fault) |->
        ##[1:REB_HI] (o_reboot || !i_cond.fault)) else $error("no reboot");
    reboot_pulse_a: assert property (o_reboot |=> !o_reboot)
        else $error("reboot too long");
    cover property (!i_service_n[*4]);
    cover property (i_cond == 7'h0c);
    cover property ($rose(i_cond.fault));
endmodule
bind sic_top sic_top_checker #(.TICK_CYCLES(TICK_CYCLES), .FAULT_MS(FAULT_MS),
    .REBOOT_MS(REBOOT_MS)) i_chk (.i_clock, .i_reset_n, .i_service_n, .i_cfg_uart, .i_cond,
    .o_primary_host_serial_port, .o_vendor_config_command_set, .o_indicator,
    .o_radio_block, .o_reboot);
`default_nettype wire

// File: dv/sic_host.sv
// host terminal model driving the service pin
`timescale 1ns/100ps
`default_nettype none
module sic_host (
    input wire logic i_hold_service,
    output logic o_service_n
);
    // pin rests high as if pulled up, low only while held
    assign o_service_n = i_hold_service ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: dv/sic_top_tb.sv
// self-checking bench for the service and indicator block
`timescale 1ns/100ps
`default_nettype none
module sic_top_tb;
    import sic_pkg::*;
    localparam int TK = 10;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic hold = 1'b0;
    logic svc_n;
    sic_uart_cfg_t cfg = {24'h002580, 4'h7, 2'h1, 2'h2};
    logic cmd_en = 1'b0;
    sic_cond_t cond = '0;
    logic [7:0] code = 8'h5a;
    sic_uart_cfg_t port;
    logic cmd_set, act, ind, blk, reboot, v0;
    logic [7:0] code_out;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    // 250 MHz clock
    always #2 i_clock = ~i_clock;
    sic_host i_host (.i_hold_service(hold), .o_service_n(svc_n));
    sic_top #(.TICK_CYCLES(TK), .TOOL_MS(4), .CMD_MS(3), .FAULT_MS(2), .REBOOT_MS(20)) i_dut (
        .i_clock, .i_reset_n, .i_service_n(svc_n), .i_cfg_uart(cfg), .i_cfg_cmd_enable(cmd_en),
        .i_cond(cond), .i_fault_code(code), .o_primary_host_serial_port(port),
        .o_vendor_config_command_set(cmd_set), .o_service_active(act), .o_indicator(ind),
        .o_radio_block(blk), .o_reboot(reboot), .o_fault_code(code_out));
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // sample 1 ns after the edge so its updates have landed
    task automatic cyc(int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask
    task automatic set_cond(logic [6:0] v);
        @(posedge i_clock);
        cond <= v;
        #1;
    endtask
    // cycles to the next indicator change, bounded
    task automatic next_edge(output int k);
        logic v;
        v = ind;
        k = 0;
        while (ind === v) begin
            cyc(1);
            k++;
            if (k > 500) begin
                check("indicator hang", 1, 0);
                close_out();
            end
        end
    endtask
    // first interval may be short, so time the third change
    task automatic blink(string what, logic [6:0] v, int ms);
        set_cond(v);
        next_edge(n);
        next_edge(n);
        next_edge(n);
        check(what, ms * TK, n);
    endtask
    initial begin
        repeat (2) @(posedge i_clock);
        i_reset_n <= 1'b1;
        cyc(5);
        check("port", cfg, port);
        check("cmd set", 0, cmd_set);
        check("radio block", 0, blk);
        check("indicator", 1, ind);
        @(posedge i_clock);
        hold <= 1'b1;
        cyc(5);
        check("port", {24'h009600, 4'h8, 2'h0, 2'h1}, port);
        check("svc active", 1, act);
        check("cmd set", 1, cmd_set);
        check("indicator", 1, ind);
        @(posedge i_clock);
        hold <= 1'b0;
        cyc(5);
        check("port", cfg, port);
        check("cmd set", 0, cmd_set);
        @(posedge i_clock);
        cmd_en <= 1'b1;
        cyc(2);
        check("cmd set", 1, cmd_set);
        set_cond(7'h01);
        cyc(2);
        check("indicator", 0, ind);
        set_cond(7'h00);
        cyc(2);
        check("indicator", 1, ind);
        set_cond(7'h02);
        cyc(2);
        check("indicator", 0, ind);
        set_cond(7'h08);
        cyc(3);
        v0 = ind;
        set_cond(7'h0c);
        set_cond(7'h08);
        cyc(1);
        check("tx toggle", !v0, ind);
        blink("tool blink", 7'h20, 4);
        blink("cmd blink", 7'h10, 3);
        set_cond(7'h40);
        n = 0;
        while (reboot !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        if (n >= 300) begin
            check("reboot hang", 1, 0);
            close_out();
        end
        check("reboot time", 1, n >= 185 && n <= 205);
        check("radio block", 1, blk);
        check("fault code", 8'h5a, code_out);
        blink("fault blink", 7'h60, 2);
        close_out();
    end
endmodule
`default_nettype wire
